// ---- isp_map.svh ----
`ifndef ISP_MAP_SVH
`define ISP_MAP_SVH

// Register subaddresses
`define ISP_REG_IPCTRL 8'h87
`define ISP_REG_PWR 8'h88
`define ISP_REG_STAT 8'h8f

// Image-port control field positions
`define ISP_OUT_PH_LO 4
`define ISP_OUT_PH_HI 5
`define ISP_GATED_PH_LO 6
`define ISP_GATED_PH_HI 7
`define ISP_OE_MODE_LO 0
`define ISP_OE_MODE_HI 1

// Power-save control field positions
`define ISP_PWR_DECODER 0
`define ISP_PWR_SCALER 1
`define ISP_PWR_AUDIO 3
`define ISP_PWR_MARKER 4
`define ISP_PWR_SOFT_RESET 5
`define ISP_PWR_GROUP1 6
`define ISP_PWR_GROUP2 7

// Reset values
`define ISP_PHASE_RST 2'h0
`define ISP_OE_MODE_RST 2'h0
`define ISP_PWR_RST 8'h00

// Bus device address, arbitrary
`define ISP_DEV_ADDR 7'h21

// Status byte bit positions
`define ISP_ST_EXPANSION_PORT_TRISTATE_PIN 7
`define ISP_ST_IMAGE_PORT_TRISTATE_PIN 6
`define ISP_ST_FIFO_ALMOST_FILLED_STATUS 5
`define ISP_ST_FIFO_OVERFLOW_STATUS 4
`define ISP_ST_MARKER 3
`define ISP_ST_OFERR 2
`define ISP_ST_FID_IN 1
`define ISP_ST_FID_OUT 0

`endif

// ---- isp_pkg.sv ----
package isp_pkg;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_DEV,
      ST_DEV_ACK,
      ST_SUB,
      ST_SUB_ACK,
      ST_WR,
      ST_WR_ACK,
      ST_RD,
      ST_RD_ACK
   } isp_bus_state_t;

   typedef enum logic [1:0] {
      OE_OFF,
      OE_SOFT,
      OE_PIN_LOW,
      OE_PIN_HIGH
   } isp_oe_mode_t;

endpackage

// ---- isp_link.sv ----
`timescale 1ns/100ps
module isp_link import isp_pkg::*; (
   // Link clock
   input wire logic link_clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   // Control from register domain
   input wire logic [1:0] out_phase_i,
   input wire logic [1:0] gated_phase_i,
   input wire logic [1:0] oe_mode_i,
   input wire logic scaler_run_i,
   input wire logic gated_sel_i,
   // Pin
   input wire logic image_port_tristate_pin_pin_i,
   // Link-side controls
   output logic out_clock_half_o,
   output logic out_clock_delay_o,
   output logic qual_half_o,
   output logic qual_delay_o,
   output logic image_port_oe_o
);

   localparam int W = 11;

   logic [W-1:0] raw;
   logic [W-1:0] meta;
   logic [W-1:0] sync;
   logic [8:0] sync_q;
   logic steady;
   logic [1:0] rst_sync;
   logic link_rst;
   logic link_ce;
   isp_oe_mode_t mode;
   logic oe_want;

   assign raw = {rstn_i, ce_i, out_phase_i, gated_phase_i, oe_mode_i, scaler_run_i, gated_sel_i, image_port_tristate_pin_pin_i};

   // Quasi-static levels, each bit through two flops
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_sync
         always_ff @(posedge link_clk_i) begin
            meta[g] <= raw[g];
            sync[g] <= meta[g];
         end
      end
   endgenerate

   always_ff @(posedge link_clk_i) begin
      rst_sync <= {rst_sync[0], sync[10]};
   end

   assign link_rst = ~rst_sync[1];
   assign link_ce = sync[9];

   // Fields cross as separate bits; act only once two samples agree
   always_ff @(posedge link_clk_i) begin
      sync_q <= sync[8:0];
   end

   assign steady = sync[8:0] == sync_q;
   assign mode = isp_oe_mode_t'(sync[4:3]);

   always_comb begin
      case (mode)
         OE_OFF: oe_want = 1'b0;
         OE_SOFT: oe_want = 1'b1;
         OE_PIN_LOW: oe_want = ~sync[0];
         OE_PIN_HIGH: oe_want = sync[0];
         default: oe_want = 1'b0;
      endcase
   end

   always_ff @(posedge link_clk_i) begin
      if (link_rst) begin
         out_clock_half_o <= 1'b0;
         out_clock_delay_o <= 1'b0;
      end else if (link_ce && steady) begin
         out_clock_half_o <= sync[7];
         out_clock_delay_o <= sync[8];
      end
   end

   // Gated phase only matters when the gated clock is selected
   always_ff @(posedge link_clk_i) begin
      if (link_rst) begin
         qual_half_o <= 1'b0;
         qual_delay_o <= 1'b0;
      end else if (link_ce && steady) begin
         qual_half_o <= sync[1] & sync[5];
         qual_delay_o <= sync[1] & sync[6];
      end
   end

   // A stopped scaler stops the port regardless of mode
   always_ff @(posedge link_clk_i) begin
      if (link_rst) begin
         image_port_oe_o <= 1'b0;
      end else if (link_ce && steady) begin
         image_port_oe_o <= oe_want & sync[2];
      end
   end

endmodule // isp_link

// ---- isp_regs.sv ----
`timescale 1ns/100ps
`include "isp_map.svh"
// Summary of operation
// - Two bits pick output clock phase
// - Two bits pick gated clock phase
// - Gated phase acts only with gated clock
// - Two bits set port output enable mode
// - Decoder power save stops decoder, slicer
// - Scaler power save stops scaler and port
// - Audio power save stops audio clocks
// - Programmed marker clears at reset
// - Status bit echoes programmed marker
// - Soft reset low holds scaler idle
// - Channel enables power analog groups
// - Status shows tristate pin levels
// - Status shows FIFO filled, overflow flags
// - Status shows output formatter error
// - Status shows input, output field ids
// - Status read live, not latched
// - Status register is read only
module isp_regs import isp_pkg::*; #(
   parameter logic [6:0] DEV_ADDR = `ISP_DEV_ADDR
) (
   // Clocks, reset, enable
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic link_clk_i,
   // Serial control bus
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Pins and scaler flags
   input wire logic image_port_tristate_pin_i,
   input wire logic expansion_port_tristate_pin_i,
   input wire logic fifo_almost_filled_status_i,
   input wire logic fifo_overflow_status_i,
   input wire logic output_formatter_error_i,
   input wire logic field_id_scaler_in_i,
   input wire logic field_id_scaler_out_i,
   // Source selections from other registers
   input wire logic gated_clock_select_i,
   input wire logic clock_source_xport_i,
   input wire logic scaler_input_xport_i,
   // Power controls
   output logic decoder_power_down_o,
   output logic vbi_power_down_o,
   output logic scaler_power_down_o,
   output logic scaler_hold_idle_o,
   output logic audio_power_down_o,
   output logic audio_out_enable_o,
   output logic analog_group1_active_o,
   output logic analog_group2_active_o,
   // Image port controls, link clock
   output logic out_clock_half_o,
   output logic out_clock_delay_o,
   output logic qual_half_o,
   output logic qual_delay_o,
   output logic image_port_oe_o
);

   localparam int NS = 7;

   // Bus synchronisers and edge history
   logic [1:0] scl_meta;
   logic [1:0] sda_meta;
   logic scl_q;
   logic sda_q;
   logic scl_d;
   logic sda_d;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   // Bus engine
   isp_bus_state_t state;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic [7:0] tx;
   logic [7:0] sub;
   logic rw;
   logic nack;
   logic wr_stb;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;

   // Registers
   logic [1:0] out_phase;
   logic [1:0] gated_phase;
   logic [1:0] oe_mode;
   logic [7:0] pwr;
   logic [7:0] status;
   logic [NS-1:0] st_raw;
   logic [NS-1:0] st_meta;
   logic [NS-1:0] st_sync;
   logic scaler_run;
   logic [7:0] rd_now;

   function automatic logic [7:0] read_reg(input logic [7:0] a);
      case (a)
         `ISP_REG_IPCTRL: read_reg = {gated_phase, out_phase, 2'h0, oe_mode};
         `ISP_REG_PWR: read_reg = {pwr[7:3], 1'b0, pwr[1:0]};
         `ISP_REG_STAT: read_reg = status;
         default: read_reg = 8'h00;
      endcase
   endfunction

   assign rd_now = read_reg(sub);

   always_ff @(posedge sys_clk_i) begin
      scl_meta <= {scl_meta[0], scl_i};
      sda_meta <= {sda_meta[0], sda_i};
   end

   assign scl_q = scl_meta[1];
   assign sda_q = sda_meta[1];

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else if (ce_i) begin
         scl_d <= scl_q;
         sda_d <= sda_q;
      end
   end

   assign scl_rise = scl_q & ~scl_d;
   assign scl_fall = ~scl_q & scl_d;
   assign start_det = scl_q & scl_d & sda_d & ~sda_q;
   assign stop_det = scl_q & scl_d & ~sda_d & sda_q;

   // Sample on rising SCL
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         shift <= 8'h00;
         nack <= 1'b0;
      end else if (ce_i && scl_rise) begin
         if (state == ST_RD_ACK) begin
            nack <= sda_q;
         end else begin
            shift <= {shift[6:0], sda_q};
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         bit_cnt <= 4'h0;
      end else if (ce_i) begin
         if (start_det) begin
            bit_cnt <= 4'h0;
         end else if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
         end else if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
         end else if (scl_fall && state inside {ST_DEV_ACK, ST_SUB_ACK, ST_WR_ACK, ST_RD_ACK}) begin
            bit_cnt <= 4'h0;
         end
      end
   end

   // Protocol state, changes on falling SCL
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         state <= ST_IDLE;
         rw <= 1'b0;
      end else if (ce_i) begin
         if (start_det) begin
            state <= ST_DEV;
         end else if (stop_det) begin
            state <= ST_IDLE;
         end else if (scl_fall) begin
            case (state)
               ST_IDLE: state <= ST_IDLE;
               ST_DEV: begin
                  if (bit_cnt == 4'h8) begin
                     rw <= shift[0];
                     state <= (shift[7:1] == DEV_ADDR) ? ST_DEV_ACK : ST_IDLE;
                  end
               end
               ST_DEV_ACK: state <= rw ? ST_RD : ST_SUB;
               ST_SUB: begin
                  if (bit_cnt == 4'h8) begin
                     state <= ST_SUB_ACK;
                  end
               end
               ST_SUB_ACK: state <= ST_WR;
               ST_WR: begin
                  if (bit_cnt == 4'h8) begin
                     state <= ST_WR_ACK;
                  end
               end
               ST_WR_ACK: state <= ST_WR;
               ST_RD: begin
                  if (bit_cnt == 4'h8) begin
                     state <= ST_RD_ACK;
                  end
               end
               ST_RD_ACK: state <= nack ? ST_IDLE : ST_RD;
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // Subaddress pointer with auto increment
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         sub <= 8'h00;
      end else if (ce_i) begin
         if (scl_fall && state == ST_SUB && bit_cnt == 4'h8) begin
            sub <= shift;
         end else if (scl_fall && state == ST_WR_ACK) begin
            sub <= sub + 8'h01;
         end else if (scl_rise && state == ST_RD_ACK) begin
            sub <= sub + 8'h01;
         end
      end
   end

   // Read data sampled as the byte starts: the live state at the read
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         tx <= 8'h00;
      end else if (ce_i && scl_fall) begin
         if (state == ST_DEV_ACK || state == ST_RD_ACK) begin
            tx <= read_reg(sub);
         end
      end
   end

   // SDA drive: ack slots and read data bits
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         sda_oe_o <= 1'b0;
      end else if (ce_i) begin
         if (start_det || stop_det) begin
            sda_oe_o <= 1'b0;
         end else if (scl_fall) begin
            case (state)
               ST_DEV: sda_oe_o <= bit_cnt == 4'h8 && shift[7:1] == DEV_ADDR;
               ST_SUB: sda_oe_o <= bit_cnt == 4'h8;
               ST_WR: sda_oe_o <= bit_cnt == 4'h8;
               ST_DEV_ACK: sda_oe_o <= rw & ~rd_now[7];
               ST_RD: sda_oe_o <= bit_cnt != 4'h8 && !tx[3'd7 - bit_cnt[2:0]];
               ST_RD_ACK: sda_oe_o <= ~nack & ~rd_now[7];
               default: sda_oe_o <= 1'b0;
            endcase
         end
      end
   end

   assign sda_o = 1'b0;

   // Write strobe at the end of each data byte
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         wr_stb <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
      end else if (ce_i) begin
         wr_stb <= scl_fall && state == ST_WR && bit_cnt == 4'h8;
         wr_addr <= sub;
         wr_data <= shift;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         out_phase <= `ISP_PHASE_RST;
         gated_phase <= `ISP_PHASE_RST;
         oe_mode <= `ISP_OE_MODE_RST;
      end else if (ce_i && wr_stb && wr_addr == `ISP_REG_IPCTRL) begin
         out_phase <= wr_data[`ISP_OUT_PH_HI:`ISP_OUT_PH_LO];
         gated_phase <= wr_data[`ISP_GATED_PH_HI:`ISP_GATED_PH_LO];
         oe_mode <= wr_data[`ISP_OE_MODE_HI:`ISP_OE_MODE_LO];
      end
   end

   // Writes to the status subaddress fall through here untouched
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         pwr <= `ISP_PWR_RST;
      end else if (ce_i && wr_stb && wr_addr == `ISP_REG_PWR) begin
         pwr <= {wr_data[7:3], 1'b0, wr_data[1:0]};
      end
   end

   // Scaler survives decoder power save only on expansion-port input and clock
   assign scaler_run = ~pwr[`ISP_PWR_SCALER] & pwr[`ISP_PWR_SOFT_RESET]
      & (~pwr[`ISP_PWR_DECODER] | (scaler_input_xport_i & clock_source_xport_i));

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         decoder_power_down_o <= 1'b0;
         vbi_power_down_o <= 1'b0;
         scaler_power_down_o <= 1'b0;
         scaler_hold_idle_o <= 1'b1;
         audio_power_down_o <= 1'b0;
         audio_out_enable_o <= 1'b0;
         analog_group1_active_o <= 1'b0;
         analog_group2_active_o <= 1'b0;
      end else if (ce_i) begin
         decoder_power_down_o <= pwr[`ISP_PWR_DECODER];
         vbi_power_down_o <= pwr[`ISP_PWR_DECODER];
         scaler_power_down_o <= ~scaler_run & ~(pwr[`ISP_PWR_DECODER] & ~pwr[`ISP_PWR_SCALER]
            & scaler_input_xport_i & clock_source_xport_i & ~pwr[`ISP_PWR_SOFT_RESET])
            & (pwr[`ISP_PWR_SCALER] | pwr[`ISP_PWR_DECODER]);
         scaler_hold_idle_o <= ~pwr[`ISP_PWR_SOFT_RESET];
         audio_power_down_o <= pwr[`ISP_PWR_AUDIO];
         audio_out_enable_o <= ~pwr[`ISP_PWR_AUDIO];
         analog_group1_active_o <= pwr[`ISP_PWR_GROUP1];
         analog_group2_active_o <= pwr[`ISP_PWR_GROUP2];
      end
   end

   // Status: two flops only, no latching beyond the crossing
   assign st_raw = {expansion_port_tristate_pin_i, image_port_tristate_pin_i,
      fifo_almost_filled_status_i, fifo_overflow_status_i, output_formatter_error_i,
      field_id_scaler_in_i, field_id_scaler_out_i};

   genvar g;
   generate
      for (g = 0; g < NS; g++) begin : g_st
         always_ff @(posedge sys_clk_i) begin
            st_meta[g] <= st_raw[g];
            st_sync[g] <= st_meta[g];
         end
      end
   endgenerate

   always_comb begin
      status = 8'h00;
      status[`ISP_ST_EXPANSION_PORT_TRISTATE_PIN] = st_sync[6];
      status[`ISP_ST_IMAGE_PORT_TRISTATE_PIN] = st_sync[5];
      status[`ISP_ST_FIFO_ALMOST_FILLED_STATUS] = st_sync[4];
      status[`ISP_ST_FIFO_OVERFLOW_STATUS] = st_sync[3];
      status[`ISP_ST_MARKER] = pwr[`ISP_PWR_MARKER];
      status[`ISP_ST_OFERR] = st_sync[2];
      status[`ISP_ST_FID_IN] = st_sync[1];
      status[`ISP_ST_FID_OUT] = st_sync[0];
   end

   isp_link u_link (
      .link_clk_i(link_clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .out_phase_i(out_phase),
      .gated_phase_i(gated_phase),
      .oe_mode_i(oe_mode),
      .scaler_run_i(scaler_run),
      .gated_sel_i(gated_clock_select_i),
      .image_port_tristate_pin_pin_i(image_port_tristate_pin_i),
      .out_clock_half_o(out_clock_half_o),
      .out_clock_delay_o(out_clock_delay_o),
      .qual_half_o(qual_half_o),
      .qual_delay_o(qual_delay_o),
      .image_port_oe_o(image_port_oe_o)
   );

endmodule // isp_regs

// ---- isp_regs_checker.sv ----
`timescale 1ns/100ps
module isp_regs_checker (
   // Clocks, reset
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic link_clk_i,
   // Bus and selections
   input wire logic scl_i,
   input wire logic sda_oe_o,
   input wire logic gated_clock_select_i,
   input wire logic clock_source_xport_i,
   // Power controls
   input wire logic decoder_power_down_o,
   input wire logic vbi_power_down_o,
   input wire logic scaler_power_down_o,
   input wire logic scaler_hold_idle_o,
   input wire logic audio_power_down_o,
   input wire logic audio_out_enable_o,
   input wire logic analog_group1_active_o,
   input wire logic analog_group2_active_o,
   // Link side
   input wire logic qual_half_o,
   input wire logic qual_delay_o,
   input wire logic image_port_oe_o
);
   property p_dec_vbi;
      @(posedge sys_clk_i) disable iff (!rstn_i) decoder_power_down_o == vbi_power_down_o;
   endproperty
   a_dec_vbi: assert property (p_dec_vbi) else $error("slicer power differs from decoder");
   property p_aud;
      @(posedge sys_clk_i) disable iff (!rstn_i) $past(rstn_i) |-> audio_out_enable_o != audio_power_down_o;
   endproperty
   a_aud: assert property (p_aud) else $error("audio enable not inverse of power down");
   property p_rst;
      @(posedge sys_clk_i) disable iff (!rstn_i) $rose(rstn_i) |-> scaler_hold_idle_o && !decoder_power_down_o
         && !analog_group1_active_o && !analog_group2_active_o;
   endproperty
   a_rst: assert property (p_rst) else $error("power outputs wrong after reset");
   property p_spd;
      @(posedge sys_clk_i) disable iff (!rstn_i)
         decoder_power_down_o && !$past(clock_source_xport_i) |-> scaler_power_down_o;
   endproperty
   a_spd: assert property (p_spd) else $error("scaler runs without expansion clock");
   property p_oe_off;
      @(posedge link_clk_i) disable iff (!rstn_i) scaler_power_down_o [*8] |-> !image_port_oe_o;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("port output on while scaler down");
   property p_qual;
      @(posedge link_clk_i) disable iff (!rstn_i) !gated_clock_select_i [*8] |-> !qual_half_o && !qual_delay_o;
   endproperty
   a_qual: assert property (p_qual) else $error("gated phase active without gated clock");
   // Register updates land in the ack slot, before its clock rises, while the bus clock is low
   property p_pwr_chg;
      @(posedge sys_clk_i) disable iff (!rstn_i)
         $changed(decoder_power_down_o) || $changed(analog_group2_active_o) |-> !scl_i;
   endproperty
   a_pwr_chg: assert property (p_pwr_chg) else $error("power control changed mid bit");
   property p_sda_chg;
      @(posedge sys_clk_i) disable iff (!rstn_i) $changed(sda_oe_o) |-> !scl_i;
   endproperty
   a_sda_chg: assert property (p_sda_chg) else $error("data line moved while bus clock high");
endmodule // isp_regs_checker

bind isp_regs isp_regs_checker u_chk (.sys_clk_i, .rstn_i, .link_clk_i, .scl_i, .sda_oe_o,
   .gated_clock_select_i, .clock_source_xport_i, .decoder_power_down_o, .vbi_power_down_o,
   .scaler_power_down_o, .scaler_hold_idle_o, .audio_power_down_o, .audio_out_enable_o,
   .analog_group1_active_o, .analog_group2_active_o, .qual_half_o, .qual_delay_o, .image_port_oe_o);

// ---- isp_host_model.sv ----
`timescale 1ns/100ps
module isp_host_model (
   // Link clock
   input wire logic link_clk_i,
   // Requested pin levels, port enable
   input wire logic image_port_tristate_pin_req_i,
   input wire logic expansion_port_tristate_pin_req_i,
   input wire logic oe_i,
   // Pins and observation
   output logic image_port_tristate_pin_o,
   output logic expansion_port_tristate_pin_o,
   output logic oe_seen_o
);
   initial begin
      image_port_tristate_pin_o = 1'b0;
      expansion_port_tristate_pin_o = 1'b0;
      oe_seen_o = 1'b0;
   end
   // Host moves its pins just after its own clock edge
   always @(posedge link_clk_i) begin
      image_port_tristate_pin_o <= image_port_tristate_pin_req_i;
      expansion_port_tristate_pin_o <= expansion_port_tristate_pin_req_i;
      oe_seen_o <= oe_i;
   end
endmodule // isp_host_model

// ---- tb.sv ----
`timescale 1ns/100ps
`include "isp_map.svh"
module tb;
   logic sys_clk_i = 0, link_clk_i = 0, rstn_i = 0, ce_i = 1, scl_i = 1, sda_m = 1;
   logic gated_clock_select_i = 0, xp = 0, oe_seen, image_port_tristate_pin_i, expansion_port_tristate_pin_i;
   logic [7:0] st = 8'h00;
   logic sda_o, sda_oe_o, decoder_power_down_o, vbi_power_down_o, scaler_power_down_o, scaler_hold_idle_o;
   logic audio_power_down_o, audio_out_enable_o, analog_group1_active_o, analog_group2_active_o;
   logic out_clock_half_o, out_clock_delay_o, qual_half_o, qual_delay_o, image_port_oe_o;
   int errors = 0, n_checks = 0, cyc = 0;
   // Open drain with pull-up
   wire sda_i = sda_m & !sda_oe_o;

   isp_regs dut (.sys_clk_i, .rstn_i, .ce_i, .link_clk_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
      .image_port_tristate_pin_i, .expansion_port_tristate_pin_i, .fifo_almost_filled_status_i(st[5]),
      .fifo_overflow_status_i(st[4]), .output_formatter_error_i(st[2]), .field_id_scaler_in_i(st[1]),
      .field_id_scaler_out_i(st[0]), .gated_clock_select_i, .clock_source_xport_i(xp),
      .scaler_input_xport_i(xp), .decoder_power_down_o, .vbi_power_down_o, .scaler_power_down_o,
      .scaler_hold_idle_o, .audio_power_down_o, .audio_out_enable_o, .analog_group1_active_o,
      .analog_group2_active_o, .out_clock_half_o, .out_clock_delay_o, .qual_half_o, .qual_delay_o,
      .image_port_oe_o);
   isp_host_model host (.link_clk_i, .image_port_tristate_pin_req_i(st[6]), .expansion_port_tristate_pin_req_i(st[7]), .oe_i(image_port_oe_o),
      .image_port_tristate_pin_o(image_port_tristate_pin_i), .expansion_port_tristate_pin_o(expansion_port_tristate_pin_i), .oe_seen_o(oe_seen));

   initial forever #10 sys_clk_i = ~sys_clk_i;
   initial begin
      #3.7;
      forever #6 link_clk_i = ~link_clk_i;
   end

   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         errors = errors + 1;
         end_of_test;
      end
   end

   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task chb(input string nm, input logic e, input logic g);
      chk(nm, {7'h00, e}, {7'h00, g});
   endtask

   // Bus clock held 10 cycles low and high, well over the minimum
   task q;
      repeat (5) @(negedge sys_clk_i);
   endtask
   task sbit(input logic b, output logic r);
      sda_m = b;
      q;
      scl_i = 1;
      q;
      r = sda_i;
      q;
      scl_i = 0;
      q;
   endtask
   task start;
      sda_m = 1;
      q;
      scl_i = 1;
      q;
      sda_m = 0;
      q;
      scl_i = 0;
      q;
   endtask
   task stop;
      sda_m = 0;
      q;
      scl_i = 1;
      q;
      sda_m = 1;
      q;
   endtask
   task wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) sbit(d[i], r);
      sbit(1'b1, r);
      ack = !r;
   endtask
   task rbyte(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         sbit(1'b1, r);
         d[i] = r;
      end
      sbit(1'b1, r);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic k;
      start;
      wbyte({`ISP_DEV_ADDR, 1'b0}, k);
      wbyte(a, k);
      wbyte(d, k);
      stop;
      repeat (2) @(negedge sys_clk_i);
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      logic k;
      start;
      wbyte({`ISP_DEV_ADDR, 1'b0}, k);
      wbyte(a, k);
      start;
      wbyte({`ISP_DEV_ADDR, 1'b1}, k);
      rbyte(d);
      stop;
   endtask

   task t_reset;
      logic [7:0] d;
      rd(`ISP_REG_PWR, d);
      chk("pwr_reset", 8'h00, d);
      rd(`ISP_REG_IPCTRL, d);
      chk("port_reset", 8'h00, d);
      chb("hold_idle", 1'b1, scaler_hold_idle_o);
      chb("oe_reset", 1'b0, image_port_oe_o);
      start;
      wbyte(8'h84, d[0]);
      chb("foreign_nack", 1'b0, d[0]);
      stop;
      rd(8'h90, d);
      chk("unmapped", 8'h00, d);
      $display("t_reset done");
   endtask

   task t_pwr;
      logic [8:0] tv [8] = '{9'h001, 9'h101, 9'h002, 9'h008, 9'h010, 9'h020, 9'h040, 9'h080};
      logic [7:0] v, d;
      for (int i = 0; i < 8; i++) begin
         xp = tv[i][8];
         v = tv[i][7:0];
         wr(`ISP_REG_PWR, v);
         chb("decoder", v[0], decoder_power_down_o);
         chb("vbi", v[0], vbi_power_down_o);
         chb("scaler", v[1] | (v[0] & !xp), scaler_power_down_o);
         chb("idle", !v[5], scaler_hold_idle_o);
         chb("audio", v[3], audio_power_down_o);
         chb("audio_oe", !v[3], audio_out_enable_o);
         chb("group1", v[6], analog_group1_active_o);
         chb("group2", v[7], analog_group2_active_o);
         rd(`ISP_REG_PWR, d);
         chk("pwr_read", v & 8'hfb, d);
      end
      xp = 0;
      $display("t_pwr done");
   endtask

   task t_stat;
      logic [7:0] d;
      wr(`ISP_REG_PWR, 8'h10);
      for (int i = 0; i < 8; i++) begin
         st = 8'h01 << i;
         rd(`ISP_REG_STAT, d);
         chk("status", st | 8'h08, d);
      end
      st = 8'ha5;
      wr(`ISP_REG_STAT, 8'h00);
      rd(`ISP_REG_STAT, d);
      chk("status_ro", 8'had, d);
      wr(`ISP_REG_PWR, 8'h00);
      rd(`ISP_REG_STAT, d);
      chk("marker_echo", 8'ha5, d);
      st = 8'h00;
      $display("t_stat done");
   endtask

   task t_oe;
      logic [1:0] m;
      logic [7:0] d;
      logic p, eo;
      wr(`ISP_REG_PWR, 8'h20);
      for (int i = 0; i < 8; i++) begin
         m = i[1:0];
         p = i[2];
         gated_clock_select_i = i[2];
         st[6] = p;
         wr(`ISP_REG_IPCTRL, {~m, m, 2'b00, m});
         repeat (20) @(negedge sys_clk_i);
         eo = (m == 2'd1) | ((m == 2'd2) & !p) | ((m == 2'd3) & p);
         chb("oe", eo, image_port_oe_o);
         chb("oe_host", eo, oe_seen);
         chb("ck_half", m[0], out_clock_half_o);
         chb("ck_delay", m[1], out_clock_delay_o);
         chb("q_half", !m[0] & i[2], qual_half_o);
         chb("q_delay", !m[1] & i[2], qual_delay_o);
      end
      wr(`ISP_REG_PWR, 8'h22);
      repeat (20) @(negedge sys_clk_i);
      chb("oe_scaler_down", 1'b0, image_port_oe_o);
      rd(`ISP_REG_IPCTRL, d);
      chk("port_read", 8'h33, d);
      $display("t_oe done");
   endtask

   initial begin
      repeat (16) @(negedge sys_clk_i);
      rstn_i = 1;
      repeat (8) @(negedge sys_clk_i);
      t_reset;
      t_pwr;
      t_stat;
      t_oe;
      end_of_test;
   end
endmodule // tb
